// [mixer_pkg.sv]
// constants, types and sample arithmetic for the digital mixer core
// Notes on behaviour
// - left transmit carries left ADC at bit 15 = 0, right ADC at 1
// - right transmit carries left ADC at bit 14 = 0, right ADC at 1
// - left ADC samples negated when record bit 1 is set
// - right ADC samples negated when record bit 0 is set
// - left DAC takes left receive at bit 15 = 0, right at 1
// - right DAC takes left receive at bit 14 = 0, right at 1
// - playback bits 1 and 0 negate left and right DAC data
// - boost field 11:10 gives 0, 6, 12 or 18 dB on received data
// - sidetone comes from the high-pass filter output, or raw ADC when record bit 8 is clear
// - left sidetone gain 12:9, -36 dB at 0 in 3 dB steps, 0 dB from 12
// - right sidetone gain 8:5 uses the same encoding as the left
// - left sidetone source 3:2: none, left ADC, right ADC, reserved
// - right sidetone source 1:0: none, left ADC, right ADC, reserved
// - scaled sidetone is added to the routed receive sample per DAC
// - record bit 8 enables the high-pass filter, reset on, feeds both
package mixer_pkg;
    localparam int SAMPLE_W = 24;
    typedef logic signed [SAMPLE_W-1:0] sample_t;
    typedef logic signed [41:0] wide_t;
    typedef struct packed {
        sample_t left;
        sample_t right;
    } stereo_t;
    localparam sample_t SMAX = 24'h7FFFFF;
    localparam sample_t SMIN = 24'h800000;
    // ************************************************
    // register map: printed index, byte address = 4 * index
    // ************************************************
    localparam logic [5:0] IDX_IF_ONE = 6'h04;
    localparam logic [5:0] IDX_IF_TWO = 6'h05;
    localparam logic [5:0] IDX_PLAY = 6'h0A;
    localparam logic [5:0] IDX_SIDE = 6'h0D;
    localparam logic [5:0] IDX_REC = 6'h0E;
    localparam int REG_COUNT = 5;
    localparam logic [15:0] IF_ONE_RST = 16'h4000;
    localparam logic [15:0] IF_TWO_RST = 16'h4000;
    localparam logic [15:0] PLAY_RST = 16'h0000;
    localparam logic [15:0] SIDE_RST = 16'h0000;
    localparam logic [15:0] REC_RST = 16'h0100;
    localparam int TX_LEFT_SEL_BIT = 15;
    localparam int TX_RIGHT_SEL_BIT = 14;
    localparam int PLAY_LEFT_SEL_BIT = 15;
    localparam int PLAY_RIGHT_SEL_BIT = 14;
    localparam int BOOST_LSB = 10;
    localparam int LEFT_INV_BIT = 1;
    localparam int RIGHT_INV_BIT = 0;
    localparam int HPF_EN_BIT = 8;
    localparam int HPF_CUT_LSB = 5;
    localparam int LEFT_GAIN_LSB = 9;
    localparam int RIGHT_GAIN_LSB = 5;
    localparam int LEFT_SRC_LSB = 2;
    localparam int RIGHT_SRC_LSB = 0;
    localparam int GAIN_FRAC = 15;
    localparam logic [3:0] GAIN_TOP_CODE = 4'hC;
    typedef enum logic [1:0] {ST_NONE, ST_LEFT, ST_RIGHT, ST_RSVD} st_src_t;
    typedef enum logic {BUS_IDLE, BUS_DONE} bus_state_t;

    function automatic sample_t sat(input wide_t v);
        if (v > wide_t'(SMAX)) return SMAX;
        if (v < wide_t'(SMIN)) return SMIN;
        return v[SAMPLE_W-1:0];
    endfunction

    function automatic sample_t negate(input sample_t x);
        return (x == SMIN) ? SMAX : -x;
    endfunction

    function automatic sample_t boost(input sample_t x, input logic [1:0] c);
        return sat(wide_t'(x) <<< c);
    endfunction

    // Q2.15 gains, -36 dB to 0 dB, 3 dB apart
    function automatic logic [16:0] st_gain(input logic [3:0] c);
        case (c)
            4'h0: return 17'h00207;
            4'h1: return 17'h002DE;
            4'h2: return 17'h0040C;
            4'h3: return 17'h005B8;
            4'h4: return 17'h00814;
            4'h5: return 17'h00B68;
            4'h6: return 17'h0101D;
            4'h7: return 17'h016C3;
            4'h8: return 17'h02027;
            4'h9: return 17'h02D6B;
            4'hA: return 17'h04027;
            4'hB: return 17'h05A9E;
            default: return 17'h08000;
        endcase
    endfunction

    // reserved source code acts as no sidetone
    function automatic sample_t st_pick(input logic [1:0] src,
                                        input stereo_t s,
                                        input logic [3:0] g);
        wide_t p;
        p = '0;
        case (st_src_t'(src))
            ST_LEFT: p = wide_t'(s.left) * wide_t'(st_gain(g));
            ST_RIGHT: p = wide_t'(s.right) * wide_t'(st_gain(g));
            default: p = '0;
        endcase
        return sat(p >>> GAIN_FRAC);
    endfunction

    // first-order DC blocker, corner set by the shift
    function automatic sample_t hpf(input sample_t x, input sample_t xp,
                                    input sample_t yp, input logic [1:0] cut);
        wide_t t;
        logic [3:0] k;
        t = '0;
        case (cut)
            2'h0: k = 4'hA;
            2'h1: k = 4'h6;
            2'h2: k = 4'h5;
            default: k = 4'h4;
        endcase
        t = wide_t'(x) - wide_t'(xp) + wide_t'(yp) - (wide_t'(yp) >>> k);
        return sat(t);
    endfunction
endpackage

// [mixer_core.sv]
// digital mixer core: routing, inversion, boost, sidetone, register slave
`timescale 1ns/1ps
module mixer_core (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // register bus, byte addressed
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // converter side
    input wire mixer_pkg::stereo_t adc_i,
    input wire logic adc_valid_i,
    output mixer_pkg::stereo_t dac_o,
    output logic dac_valid_o,
    // audio interface side
    input wire mixer_pkg::stereo_t serial_play_input_i,
    input wire logic rx_valid_i,
    output mixer_pkg::stereo_t tx_o,
    output logic tx_valid_o
);

    // ************************************************
    // register file
    // ************************************************
    logic [15:0] regs [mixer_pkg::REG_COUNT];
    mixer_pkg::bus_state_t bus_state;

    function automatic logic [3:0] slot_of(input logic [7:0] a);
        case (a[7:2])
            mixer_pkg::IDX_IF_ONE: return 4'h8;
            mixer_pkg::IDX_IF_TWO: return 4'h9;
            mixer_pkg::IDX_PLAY: return 4'hA;
            mixer_pkg::IDX_SIDE: return 4'hB;
            mixer_pkg::IDX_REC: return 4'hC;
            default: return 4'h0;
        endcase
    endfunction

    logic [3:0] hit;
    logic [2:0] slot;
    assign hit = slot_of(avs_address_i);
    assign slot = hit[2:0];

    // one wait cycle per access keeps decode off the read path
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bus_state <= mixer_pkg::BUS_IDLE;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h00000000;
        end else begin
            case (bus_state)
                mixer_pkg::BUS_IDLE: begin
                    if (avs_read_i || avs_write_i) begin
                        bus_state <= mixer_pkg::BUS_DONE;
                        avs_waitrequest_o <= 1'b0;
                        avs_readdata_o <= 32'h00000000;
                        if (avs_read_i && hit[3]) begin
                            avs_readdata_o <= {16'h0000, regs[slot]};
                        end
                    end
                end
                mixer_pkg::BUS_DONE: begin
                    bus_state <= mixer_pkg::BUS_IDLE;
                    avs_waitrequest_o <= 1'b1;
                end
                default: begin
                    bus_state <= mixer_pkg::BUS_IDLE;
                    avs_waitrequest_o <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            regs[0] <= mixer_pkg::IF_ONE_RST;
            regs[1] <= mixer_pkg::IF_TWO_RST;
            regs[2] <= mixer_pkg::PLAY_RST;
            regs[3] <= mixer_pkg::SIDE_RST;
            regs[4] <= mixer_pkg::REC_RST;
        end else if (avs_write_i && !avs_waitrequest_o && hit[3]) begin
            if (avs_byteenable_i[0]) begin
                regs[slot][7:0] <= avs_writedata_i[7:0];
            end
            if (avs_byteenable_i[1]) begin
                regs[slot][15:8] <= avs_writedata_i[15:8];
            end
        end
    end

    // ************************************************
    // control fields
    // ************************************************
    logic tx_left_source_sel;
    logic tx_right_source_sel;
    logic play_left_source_sel;
    logic play_right_source_sel;
    logic [1:0] boost_code;
    logic play_left_invert;
    logic play_right_invert;
    logic [3:0] left_sidetone_gain;
    logic [3:0] right_sidetone_gain;
    logic [1:0] left_sidetone_source;
    logic [1:0] right_sidetone_source;
    logic rec_highpass_enable;
    logic [1:0] hpf_cut;
    logic rec_left_invert;
    logic rec_right_invert;

    assign tx_left_source_sel = regs[0][mixer_pkg::TX_LEFT_SEL_BIT];
    assign tx_right_source_sel = regs[0][mixer_pkg::TX_RIGHT_SEL_BIT];
    assign play_left_source_sel = regs[1][mixer_pkg::PLAY_LEFT_SEL_BIT];
    assign play_right_source_sel = regs[1][mixer_pkg::PLAY_RIGHT_SEL_BIT];
    assign boost_code = regs[1][mixer_pkg::BOOST_LSB +: 2];
    assign play_left_invert = regs[2][mixer_pkg::LEFT_INV_BIT];
    assign play_right_invert = regs[2][mixer_pkg::RIGHT_INV_BIT];
    assign left_sidetone_gain = regs[3][mixer_pkg::LEFT_GAIN_LSB +: 4];
    assign right_sidetone_gain = regs[3][mixer_pkg::RIGHT_GAIN_LSB +: 4];
    assign left_sidetone_source = regs[3][mixer_pkg::LEFT_SRC_LSB +: 2];
    assign right_sidetone_source = regs[3][mixer_pkg::RIGHT_SRC_LSB +: 2];
    assign rec_highpass_enable = regs[4][mixer_pkg::HPF_EN_BIT];
    assign hpf_cut = regs[4][mixer_pkg::HPF_CUT_LSB +: 2];
    assign rec_left_invert = regs[4][mixer_pkg::LEFT_INV_BIT];
    assign rec_right_invert = regs[4][mixer_pkg::RIGHT_INV_BIT];

    // ************************************************
    // record path
    // ************************************************
    mixer_pkg::stereo_t adc_prev;
    mixer_pkg::stereo_t hpf_y;
    mixer_pkg::stereo_t next_hpf;
    mixer_pkg::stereo_t rec;

    always_comb begin
        if (rec_highpass_enable) begin
            next_hpf.left = mixer_pkg::hpf(adc_i.left, adc_prev.left,
                                           hpf_y.left, hpf_cut);
            next_hpf.right = mixer_pkg::hpf(adc_i.right, adc_prev.right,
                                            hpf_y.right, hpf_cut);
        end else begin
            next_hpf = adc_i;
        end
        rec.left = rec_left_invert ? mixer_pkg::negate(next_hpf.left)
                                   : next_hpf.left;
        rec.right = rec_right_invert ? mixer_pkg::negate(next_hpf.right)
                                     : next_hpf.right;
    end

    // filter history doubles as the sidetone source
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            adc_prev <= '0;
            hpf_y <= '0;
        end else if (adc_valid_i) begin
            adc_prev <= adc_i;
            hpf_y <= next_hpf;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_o <= '0;
            tx_valid_o <= 1'b0;
        end else begin
            tx_valid_o <= adc_valid_i;
            if (adc_valid_i) begin
                tx_o.left <= tx_left_source_sel ? rec.right : rec.left;
                tx_o.right <= tx_right_source_sel ? rec.right : rec.left;
            end
        end
    end

    // ************************************************
    // playback path
    // ************************************************
    mixer_pkg::sample_t routed_l;
    mixer_pkg::sample_t routed_r;
    mixer_pkg::sample_t shaped_l;
    mixer_pkg::sample_t shaped_r;
    mixer_pkg::sample_t side_l;
    mixer_pkg::sample_t side_r;
    mixer_pkg::stereo_t next_dac;

    always_comb begin
        routed_l = play_left_source_sel ? serial_play_input_i.right
                                        : serial_play_input_i.left;
        routed_r = play_right_source_sel ? serial_play_input_i.right
                                         : serial_play_input_i.left;
        routed_l = mixer_pkg::boost(routed_l, boost_code);
        routed_r = mixer_pkg::boost(routed_r, boost_code);
        shaped_l = play_left_invert ? mixer_pkg::negate(routed_l)
                                    : routed_l;
        shaped_r = play_right_invert ? mixer_pkg::negate(routed_r)
                                     : routed_r;
        side_l = mixer_pkg::st_pick(left_sidetone_source, hpf_y,
                                    left_sidetone_gain);
        side_r = mixer_pkg::st_pick(right_sidetone_source, hpf_y,
                                    right_sidetone_gain);
        // saturating sum, clipping beats wrap-around noise
        next_dac.left = mixer_pkg::sat(mixer_pkg::wide_t'(shaped_l)
                                       + mixer_pkg::wide_t'(side_l));
        next_dac.right = mixer_pkg::sat(mixer_pkg::wide_t'(shaped_r)
                                        + mixer_pkg::wide_t'(side_r));
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dac_o <= '0;
            dac_valid_o <= 1'b0;
        end else begin
            dac_valid_o <= rx_valid_i;
            if (rx_valid_i) begin
                dac_o <= next_dac;
            end
        end
    end

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_raw_adc;
        adc_valid_i && !rec_highpass_enable;
    endsequence

    sequence s_plain_play;
        rx_valid_i && boost_code == 2'h0 && !play_left_invert
            && !play_right_invert
            && left_sidetone_source == 2'h0
            && right_sidetone_source == 2'h0;
    endsequence

    property p_tx_left;
        s_raw_adc ##0 (!rec_left_invert && !rec_right_invert) |=>
            tx_o.left == ($past(tx_left_source_sel) ? $past(adc_i.right)
                                                    : $past(adc_i.left));
    endproperty
    a_tx_left: assert property (p_tx_left) else $error("tx left route");

    property p_tx_right;
        s_raw_adc ##0 (!rec_left_invert && !rec_right_invert) |=>
            tx_o.right == ($past(tx_right_source_sel) ? $past(adc_i.right)
                                                      : $past(adc_i.left));
    endproperty
    a_tx_right: assert property (p_tx_right) else $error("tx right route");

    property p_rec_left_inv;
        s_raw_adc ##0 (rec_left_invert && !tx_left_source_sel
            && adc_i.left != mixer_pkg::SMIN) |=>
            tx_o.left == -$past(adc_i.left);
    endproperty
    a_rec_left_inv: assert property (p_rec_left_inv)
        else $error("left record invert");

    property p_rec_right_inv;
        s_raw_adc ##0 (rec_right_invert && tx_right_source_sel) |=>
            tx_o.right == mixer_pkg::negate($past(adc_i.right));
    endproperty
    a_rec_right_inv: assert property (p_rec_right_inv)
        else $error("right record invert");

    property p_neg_sat;
        s_raw_adc ##0 (rec_left_invert && !tx_left_source_sel
            && adc_i.left == mixer_pkg::SMIN) |=>
            tx_o.left == mixer_pkg::SMAX;
    endproperty
    a_neg_sat: assert property (p_neg_sat) else $error("negate saturate");

    property p_play_route;
        s_plain_play |=> dac_valid_o
            && dac_o.left == ($past(play_left_source_sel)
                ? $past(serial_play_input_i.right)
                : $past(serial_play_input_i.left))
            && dac_o.right == ($past(play_right_source_sel)
                ? $past(serial_play_input_i.right)
                : $past(serial_play_input_i.left));
    endproperty
    a_play_route: assert property (p_play_route)
        else $error("dac routing");

    property p_play_boost;
        rx_valid_i && boost_code == 2'h3 && !play_left_invert
            && !play_left_source_sel && left_sidetone_source == 2'h0
            && serial_play_input_i.left == 24'h000100 |=>
            dac_o.left == 24'h000800;
    endproperty
    a_play_boost: assert property (p_play_boost) else $error("boost");

    property p_play_inv;
        rx_valid_i && boost_code == 2'h0 && play_right_invert
            && right_sidetone_source == 2'h0 |=>
            dac_o.right == mixer_pkg::negate($past(routed_r));
    endproperty
    a_play_inv: assert property (p_play_inv) else $error("dac invert");

    property p_sidetone;
        rx_valid_i && boost_code == 2'h0 && !play_left_invert
            && !play_left_source_sel && serial_play_input_i.left == '0
            && left_sidetone_source == 2'h1
            && left_sidetone_gain >= mixer_pkg::GAIN_TOP_CODE |=>
            dac_o.left == $past(hpf_y.left);
    endproperty
    a_sidetone: assert property (p_sidetone)
        else $error("sidetone unity");

    property p_bus_answer;
        (avs_read_i || avs_write_i) && avs_waitrequest_o
            && bus_state == mixer_pkg::BUS_IDLE |=>
            !avs_waitrequest_o ##1 avs_waitrequest_o;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus timing");

    property p_rsvd;
        rx_valid_i
            && right_sidetone_source == 2'h3
            && boost_code == 2'h0
            && !play_right_invert
            && play_right_source_sel |=>
            dac_o.right == $past(serial_play_input_i.right);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved source");

    property p_st_r;
        rx_valid_i
            && boost_code == 2'h0
            && !play_right_invert
            && serial_play_input_i == '0
            && right_sidetone_source == 2'h2
            && right_sidetone_gain >= mixer_pkg::GAIN_TOP_CODE |=>
            dac_o.right == $past(hpf_y.right);
    endproperty
    a_st_r: assert property (p_st_r) else $error("right sidetone");

endmodule // mixer_core

// [mixer_far_end.sv]
// converter and serial-source model that feeds the mixer core
`timescale 1ns/1ps
module mixer_far_end (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // bench request
    input wire logic req_i,
    input wire logic [3:0] gap_i,
    input wire mixer_pkg::stereo_t adc_d_i,
    input wire mixer_pkg::stereo_t rx_d_i,
    // towards the core
    output mixer_pkg::stereo_t adc_o,
    output logic adc_valid_o,
    output mixer_pkg::stereo_t rx_o,
    output logic rx_valid_o
);
    // ************************************************
    // one ADC pair, then one playback pair after the gap
    // ************************************************
    logic [4:0] wait_cnt;
    logic pend;
    mixer_pkg::stereo_t rx_hold;
    logic take;

    assign take = req_i && !pend;

    // record pair always leads the playback pair, one each per frame,
    // so both paths run at one rate and the ADC is up first
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            adc_valid_o <= 1'b0;
            rx_valid_o <= 1'b0;
            pend <= 1'b0;
            wait_cnt <= '0;
            adc_o <= '0;
            rx_o <= '0;
            rx_hold <= '0;
        end else begin
            adc_valid_o <= take;
            rx_valid_o <= 1'b0;
            // data lines toggle outside their strobe, never hold
            adc_o <= take ? adc_d_i : ~adc_o;
            rx_o <= ~rx_o;
            if (take) begin
                pend <= 1'b1;
                wait_cnt <= {1'b0, gap_i};
                // headroom kept except in saturation cases
                rx_hold <= rx_d_i;
            end else if (pend && wait_cnt != 5'h00) begin
                wait_cnt <= wait_cnt - 5'h01;
            end else if (pend) begin
                pend <= 1'b0;
                rx_valid_o <= 1'b1;
                rx_o <= rx_hold;
            end
        end
    end
endmodule // mixer_far_end

// [testbench.sv]
// self-checking bench for the mixer core
`timescale 1ns/1ps
module testbench;
    logic sys_clk_i, rst_i, avs_read_i, avs_write_i, req, tx_valid_o;
    logic avs_waitrequest_o, adc_valid, rx_valid, dac_valid_o;
    logic [7:0] avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o;
    logic [3:0] avs_byteenable_i, gap;
    mixer_pkg::stereo_t adc_d, rx_d, adc, rx, tx_o, dac_o, tx_s, dac_s, a, r;
    mixer_pkg::sample_t f, st;
    logic [1:0] k;
    int checks, err_total, i;

    mixer_core dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .adc_i(adc),
        .adc_valid_i(adc_valid), .dac_o(dac_o), .dac_valid_o(dac_valid_o),
        .serial_play_input_i(rx), .rx_valid_i(rx_valid), .tx_o(tx_o),
        .tx_valid_o(tx_valid_o));
    mixer_far_end far_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_i(req),
        .gap_i(gap), .adc_d_i(adc_d), .rx_d_i(rx_d), .adc_o(adc),
        .adc_valid_o(adc_valid), .rx_o(rx), .rx_valid_o(rx_valid));

    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end

    // ************************************************
    // helpers
    // ************************************************
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic hang();
        err_total++;
        $display("Error at %0t: wait ran out", $time);
        finish_test();
    endtask

    task automatic bus(input logic wen, input logic [7:0] ad,
                       input logic [31:0] d, input logic [3:0] be,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        avs_address_i <= ad;
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        avs_write_i <= wen;
        avs_read_i <= !wen;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 20);
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        if (avs_waitrequest_o !== 1'b0) hang();
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] d,
                      input logic [3:0] be);
        logic [31:0] q;
        bus(1'b1, ad, d, be, q);
    endtask

    task automatic rd(input logic [7:0] ad, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, ad, 32'h0, 4'hF, q);
        checks++;
        if (q !== e) begin
            err_total++;
            $display("Error at %0t: read %h got %h want %h", $time, ad, q, e);
        end
    endtask

    task automatic xfer(input mixer_pkg::stereo_t av,
                        input mixer_pkg::stereo_t rv, input logic [3:0] g);
        int n;
        n = 0;
        tx_s = 'x;
        dac_s = 'x;
        @(posedge sys_clk_i);
        adc_d <= av;
        rx_d <= rv;
        gap <= g;
        req <= 1'b1;
        @(posedge sys_clk_i);
        req <= 1'b0;
        while (dac_valid_o !== 1'b1 && n < 40) begin
            @(negedge sys_clk_i);
            if (tx_valid_o === 1'b1) tx_s = tx_o;
            n++;
        end
        if (dac_valid_o !== 1'b1) hang();
        dac_s = dac_o;
    endtask

    task automatic chk(input mixer_pkg::sample_t got,
                       input mixer_pkg::sample_t e, input int tol);
        int d;
        d = int'(got) - int'(e);
        checks++;
        if ($isunknown(got) || d > tol || -d > tol) begin
            err_total++;
            $display("Error at %0t: got %h want %h", $time, got, e);
        end
    endtask

    function automatic mixer_pkg::sample_t clampi(input int v);
        if (v > 8388607) return 24'h7FFFFF;
        if (v < -8388608) return 24'h800000;
        return v[23:0];
    endfunction

    function automatic mixer_pkg::sample_t sadd(input mixer_pkg::sample_t x,
                                                input mixer_pkg::sample_t y);
        return clampi(int'(x) + int'(y));
    endfunction

    function automatic mixer_pkg::sample_t neg(input mixer_pkg::sample_t x);
        return (x === 24'h800000) ? 24'h7FFFFF : -x;
    endfunction

    // attenuation from the gain code, 3 dB a step from -36 dB
    function automatic mixer_pkg::sample_t st_exp(input mixer_pkg::sample_t x,
                                                  input int g);
        real v;
        v = real'(int'(x));
        if (g < 12) v = v * 10.0 ** (-(36 - 3 * g) / 20.0);
        return mixer_pkg::sample_t'(int'(v));
    endfunction

    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        rst_i = 1'b1;
        {avs_read_i, avs_write_i, req} = 3'h0;
        avs_address_i = 8'h00;
        avs_writedata_i = 32'h0;
        avs_byteenable_i = 4'hF;
        gap = 4'h2;
        adc_d = '0;
        rx_d = '0;
        checks = 0;
        err_total = 0;
        repeat (20) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rd(8'h10, 32'h4000);
        rd(8'h14, 32'h4000);
        rd(8'h28, 32'h0);
        rd(8'h34, 32'h0);
        rd(8'h38, 32'h0100);
        wr(8'h00, 32'hFFFF, 4'hF);
        rd(8'h00, 32'h0);
        wr(8'h10, 32'hFFFF_A5C3, 4'hF);
        rd(8'h10, 32'hA5C3);
        wr(8'h10, 32'h11, 4'h1);
        rd(8'h10, 32'hA511);
        wr(8'h10, 32'h4000, 4'hF);
        $display("test registers done");
        // filter on from reset; sidetone 0 dB, left ADC into left DAC
        wr(8'h34, 32'h1804, 4'hF);
        a = {24'h200000, 24'hE00000};
        r = {24'h000100, 24'h000200};
        xfer(a, r, 4'h2);
        chk(tx_s.left, a.left, 0);
        chk(tx_s.right, a.right, 0);
        chk(dac_s.left, sadd(r.left, a.left), 0);
        chk(dac_s.right, r.right, 0);
        xfer(a, r, 4'h9);
        f = a.left - (a.left >>> 10);
        chk(tx_s.left, f, 0);
        chk(dac_s.left, sadd(r.left, f), 0);
        $display("test filter done");
        wr(8'h34, 32'h0, 4'hF);
        a.right = 24'h0ABCDE;
        r = {24'h012345, 24'h800000};
        for (i = 0; i < 4; i++) begin
            k = i[1:0];
            a.left = k[0] ? 24'h800000 : 24'h123456;
            wr(8'h10, {16'h0, k, 14'h0}, 4'hF);
            wr(8'h14, {16'h0, k, 14'h0}, 4'hF);
            wr(8'h38, {30'h0, ~k[1], k[0]}, 4'hF);
            wr(8'h28, {30'h0, ~k}, 4'hF);
            xfer(a, r, 4'h0);
            f = k[1] ? a.left : neg(a.left);
            st = k[0] ? neg(a.right) : a.right;
            chk(tx_s.left, k[1] ? st : f, 0);
            chk(tx_s.right, k[0] ? st : f, 0);
            f = k[1] ? r.right : neg(r.left);
            chk(dac_s.left, f, 0);
            f = k[0] ? r.right : neg(r.left);
            chk(dac_s.right, f, 0);
        end
        $display("test routing done");
        wr(8'h28, 32'h0, 4'hF);
        r = {24'h000100, 24'h300000};
        for (i = 0; i < 4; i++) begin
            k = i[1:0];
            wr(8'h14, {16'h0, 4'h4, k, 10'h0}, 4'hF);
            xfer(a, r, 4'h1);
            chk(dac_s.left, clampi(int'(r.left) * (1 << k)), 0);
            chk(dac_s.right, clampi(int'(r.right) * (1 << k)), 0);
        end
        $display("test boost done");
        wr(8'h14, 32'h4000, 4'hF);
        a = {24'h400000, 24'hC00000};
        for (i = 0; i < 16; i++) begin
            wr(8'h34, {19'h0, i[3:0], i[3:0], 5'h06}, 4'hF);
            xfer(a, '0, 4'h3);
            chk(dac_s.left, st_exp(a.left, i), i < 12 ? 1000 : 0);
            chk(dac_s.right, st_exp(a.right, i), i < 12 ? 1000 : 0);
        end
        $display("test sidetone gain done");
        a = {24'h100000, 24'h020000};
        r = {24'h7F0000, 24'h000100};
        for (i = 0; i < 4; i++) begin
            k = i[1:0];
            wr(8'h34, {19'h0, 4'hC, 4'hC, 1'b0, k, k}, 4'hF);
            xfer(a, r, 4'h2);
            st = (k == 2'h1) ? a.left : (k == 2'h2) ? a.right : 24'h0;
            chk(dac_s.left, sadd(r.left, st), 0);
            chk(dac_s.right, sadd(r.right, st), 0);
        end
        $display("test sidetone source done");
        finish_test();
    end
endmodule // testbench
